// *** usb_ep_pkg.sv ***
package usb_ep_pkg;

    // Register file geometry.
    localparam int NUM_EP = 16;
    localparam logic [7:0] ADDR_EP_BASE = 8'h00;
    localparam logic [7:0] ADDR_EP_LAST = 8'h3C;
    localparam logic [7:0] ADDR_STALL_STATUS = 8'h40;
    localparam logic [7:0] ADDR_STALL_MASK = 8'h44;
    localparam logic [7:0] ADDR_MODE = 8'h48;

    // Endpoint control field positions.
    localparam int BIT_LOW_SPEED = 7;
    localparam int BIT_NAK_RETRY_DIS = 6;
    localparam int BIT_CTRL_DIS = 4;
    localparam int BIT_RX = 3;
    localparam int BIT_TX = 2;
    localparam int BIT_STALL = 1;
    localparam int BIT_HSHK = 0;

    // Writable bits: bit 5 never stores, bits 7 and 6 only in endpoint zero in host mode.
    localparam logic [7:0] EP_WRITE_MASK_ZERO = 8'hDF;
    localparam logic [7:0] EP_WRITE_MASK_OTHER = 8'h1F;
    localparam logic [7:0] EP_RESET = 8'h00;
    localparam logic [15:0] STALL_RESET = 16'h0000;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic low_speed_direct_connect;
        logic nak_retry_disable;
        logic unused5;
        logic control_transfer_disable;
        logic receive_enable;
        logic transmit_enable;
        logic stall_status;
        logic handshake_enable;
    } endpoint_control_t;

    typedef struct packed {
        logic rx;
        logic tx;
        logic setup;
        logic handshake;
    } endpoint_grant_t;

endpackage : usb_ep_pkg

// *** usb_ep_slice.sv ***
`timescale 1ns/10ps
module usb_ep_slice #(
    parameter bit IS_EP_ZERO = 1'b0
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Software write.
    input wire logic write_en,
    input wire logic [7:0] write_data,
    // Bus side.
    input wire logic stall_event,
    input wire logic host_mode,
    // Register contents and derived grants.
    output usb_ep_pkg::endpoint_control_t ctrl,
    output usb_ep_pkg::endpoint_grant_t grant
);

    typedef struct packed {
        usb_ep_pkg::endpoint_control_t ctrl;
        usb_ep_pkg::endpoint_grant_t grant;
    } slice_state_t;

    slice_state_t s;
    slice_state_t next_s;
    logic zero_bits_live;

    assign zero_bits_live = IS_EP_ZERO && host_mode;

    always_comb begin
        next_s = s;
        if (write_en) begin
            next_s.ctrl = write_data & (zero_bits_live ? usb_ep_pkg::EP_WRITE_MASK_ZERO
                                                       : usb_ep_pkg::EP_WRITE_MASK_OTHER);
        end
        if (!zero_bits_live) begin
            next_s.ctrl.low_speed_direct_connect = 1'b0;
            next_s.ctrl.nak_retry_disable = 1'b0;
        end
        if (stall_event) begin
            next_s.ctrl.stall_status = 1'b1;
        end
        next_s.grant.rx = next_s.ctrl.receive_enable;
        next_s.grant.tx = next_s.ctrl.transmit_enable;
        next_s.grant.setup = next_s.ctrl.receive_enable && next_s.ctrl.transmit_enable
                             && !next_s.ctrl.control_transfer_disable;
        next_s.grant.handshake = next_s.ctrl.handshake_enable;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '{ctrl: usb_ep_pkg::EP_RESET, grant: '0};
        end else begin
            s <= next_s;
        end
    end

    assign ctrl = s.ctrl;
    assign grant = s.grant;

    a_stall_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        stall_event |=> ctrl.stall_status)
        else $error("stall event did not set stall status");
    a_setup_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
        !(ctrl.receive_enable && ctrl.transmit_enable) |-> !grant.setup)
        else $error("setup granted without both directions");
    a_host_bits_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        !zero_bits_live |=> !ctrl.low_speed_direct_connect && !ctrl.nak_retry_disable)
        else $error("host-only bits set outside endpoint zero host mode");
    a_bit5_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        write_en && write_data[5] |=> !ctrl.unused5)
        else $error("bit 5 stored a write");

endmodule : usb_ep_slice

// *** usb_ep_irq.sv ***
`timescale 1ns/10ps
module usb_ep_irq #(
    parameter int WIDTH = 16
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Events and software access.
    input wire logic [WIDTH-1:0] event_in,
    input wire logic [WIDTH-1:0] clear_bits,
    input wire logic mask_we,
    input wire logic [WIDTH-1:0] mask_data,
    // State and request.
    output logic [WIDTH-1:0] status,
    output logic [WIDTH-1:0] mask,
    output logic irq
);

    typedef struct packed {
        logic [WIDTH-1:0] status;
        logic [WIDTH-1:0] mask;
        logic irq;
    } irq_state_t;

    irq_state_t s;
    irq_state_t next_s;

    always_comb begin
        next_s = s;
        // A new event in the clearing cycle stays set.
        next_s.status = (s.status & ~clear_bits) | event_in;
        if (mask_we) begin
            next_s.mask = mask_data;
        end
        next_s.irq = |(next_s.status & next_s.mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign status = s.status;
    assign mask = s.mask;
    assign irq = s.irq;

endmodule : usb_ep_irq

// *** usb_endpoint_control.sv ***
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
module usb_endpoint_control (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address.
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    // AXI4-Lite write data.
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response.
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address.
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    // AXI4-Lite read data.
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // USB engine side.
    input wire logic host_mode,
    input wire logic [15:0] stall_event,
    output logic [15:0] receive_enable,
    output logic [15:0] transmit_enable,
    output logic [15:0] setup_enable,
    output logic [15:0] handshake_enable,
    output logic low_speed_direct_connect,
    output logic nak_retry_disable,
    // Interrupt.
    output logic irq
);

    typedef struct packed {
        logic aw_ready;
        logic w_ready;
        logic aw_got;
        logic w_got;
        logic [7:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic b_valid;
        logic [1:0] b_resp;
        logic ar_ready;
        logic r_valid;
        logic [31:0] r_data;
        logic [1:0] r_resp;
    } bus_state_t;

    bus_state_t s;
    bus_state_t next_s;

    usb_ep_pkg::endpoint_control_t ep_ctrl [usb_ep_pkg::NUM_EP];
    usb_ep_pkg::endpoint_grant_t ep_grant [usb_ep_pkg::NUM_EP];
    logic [15:0] ep_we;
    logic [15:0] stall_status;
    logic [15:0] stall_mask;
    logic [15:0] stall_clear;
    logic [15:0] lane_mask;
    logic stall_mask_we;
    logic write_fire;
    logic write_legal;
    logic read_fire;

    // Decoded access to one aligned word.
    function automatic logic addr_legal(input logic [7:0] addr);
        logic [7:0] word;
        word = {addr[7:2], 2'h0};
        addr_legal = (word <= usb_ep_pkg::ADDR_EP_LAST) || (word == usb_ep_pkg::ADDR_STALL_STATUS)
                     || (word == usb_ep_pkg::ADDR_STALL_MASK) || (word == usb_ep_pkg::ADDR_MODE);
    endfunction : addr_legal

    function automatic logic [31:0] read_word(input logic [7:0] addr);
        logic [7:0] word;
        word = {addr[7:2], 2'h0};
        read_word = 32'h0000_0000;
        if (word <= usb_ep_pkg::ADDR_EP_LAST) begin
            read_word = {24'h00_0000, ep_ctrl[addr[5:2]]};
        end else if (word == usb_ep_pkg::ADDR_STALL_STATUS) begin
            read_word = {16'h0000, stall_status};
        end else if (word == usb_ep_pkg::ADDR_STALL_MASK) begin
            read_word = {16'h0000, stall_mask};
        end else if (word == usb_ep_pkg::ADDR_MODE) begin
            read_word = {31'h0000_0000, host_mode};
        end
    endfunction : read_word

    assign write_fire = s.aw_got && s.w_got && !s.b_valid;
    assign write_legal = addr_legal(s.aw_addr);
    assign read_fire = s.ar_ready && arvalid;
    assign lane_mask = {{8{s.w_strb[1]}}, {8{s.w_strb[0]}}};

    // Register strobes, each qualified by the byte lanes it covers.
    always_comb begin
        ep_we = 16'h0000;
        stall_clear = 16'h0000;
        stall_mask_we = 1'b0;
        if (write_fire && write_legal) begin
            if (s.aw_addr[7:6] == 2'h0) begin
                ep_we[s.aw_addr[5:2]] = s.w_strb[0];
            end else if ({s.aw_addr[7:2], 2'h0} == usb_ep_pkg::ADDR_STALL_STATUS) begin
                stall_clear = s.w_data[15:0] & lane_mask;
            end else if ({s.aw_addr[7:2], 2'h0} == usb_ep_pkg::ADDR_STALL_MASK) begin
                stall_mask_we = |s.w_strb[1:0];
            end
        end
    end

    always_comb begin
        next_s = s;
        if (s.aw_ready && awvalid) begin
            next_s.aw_got = 1'b1;
            next_s.aw_addr = awaddr;
        end
        if (s.w_ready && wvalid) begin
            next_s.w_got = 1'b1;
            next_s.w_data = wdata;
            next_s.w_strb = wstrb;
        end
        if (s.b_valid && bready) begin
            next_s.b_valid = 1'b0;
        end
        if (write_fire) begin
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
            next_s.b_valid = 1'b1;
            next_s.b_resp = write_legal ? usb_ep_pkg::RESP_OKAY : usb_ep_pkg::RESP_SLVERR;
        end
        next_s.aw_ready = !next_s.aw_got && !next_s.b_valid;
        next_s.w_ready = !next_s.w_got && !next_s.b_valid;
        if (s.r_valid && rready) begin
            next_s.r_valid = 1'b0;
        end
        if (read_fire) begin
            next_s.r_valid = 1'b1;
            next_s.r_data = read_word(araddr);
            next_s.r_resp = addr_legal(araddr) ? usb_ep_pkg::RESP_OKAY : usb_ep_pkg::RESP_SLVERR;
        end
        next_s.ar_ready = !next_s.r_valid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    genvar g;
    generate
        for (g = 0; g < usb_ep_pkg::NUM_EP; g++) begin : gen_ep
            usb_ep_slice #(
                .IS_EP_ZERO(g == 0)
            ) u_slice (
                .aclk(aclk),
                .aresetn(aresetn),
                .write_en(ep_we[g]),
                .write_data(s.w_data[7:0]),
                .stall_event(stall_event[g]),
                .host_mode(host_mode),
                .ctrl(ep_ctrl[g]),
                .grant(ep_grant[g])
            );
            assign receive_enable[g] = ep_grant[g].rx;
            assign transmit_enable[g] = ep_grant[g].tx;
            assign setup_enable[g] = ep_grant[g].setup;
            assign handshake_enable[g] = ep_grant[g].handshake;
        end
    endgenerate

    usb_ep_irq #(
        .WIDTH(16)
    ) u_irq (
        .aclk(aclk),
        .aresetn(aresetn),
        .event_in(stall_event),
        .clear_bits(stall_clear),
        .mask_we(stall_mask_we),
        .mask_data((stall_mask & ~lane_mask) | (s.w_data[15:0] & lane_mask)),
        .status(stall_status),
        .mask(stall_mask),
        .irq(irq)
    );

    assign low_speed_direct_connect = ep_ctrl[0].low_speed_direct_connect;
    assign nak_retry_disable = ep_ctrl[0].nak_retry_disable;

    assign awready = s.aw_ready;
    assign wready = s.w_ready;
    assign bvalid = s.b_valid;
    assign bresp = s.b_resp;
    assign arready = s.ar_ready;
    assign rvalid = s.r_valid;
    assign rdata = s.r_data;
    assign rresp = s.r_resp;

    a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        write_fire |=> bvalid && (bresp == (write_legal ? usb_ep_pkg::RESP_OKAY : usb_ep_pkg::RESP_SLVERR)))
        else $error("write response missing or wrong");
    a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        read_fire |=> rvalid && !arready)
        else $error("read response missing");
    a_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        read_fire && (araddr[7:6] == 2'h0) |=> rdata[31:8] == 24'h00_0000)
        else $error("endpoint upper bits not zero");
    a_low_speed: assert property (@(posedge aclk) disable iff (!aresetn)
        ep_we[0] && host_mode && s.w_data[7] ##1 host_mode |=> low_speed_direct_connect)
        else $error("low-speed direct connect not enabled");
    a_retry_off: assert property (@(posedge aclk) disable iff (!aresetn)
        ep_we[0] && host_mode && !s.w_data[6] |=> !nak_retry_disable)
        else $error("retry disable remained set");
    a_setup_block: assert property (@(posedge aclk) disable iff (!aresetn)
        ep_we[1] && (s.w_data[4:2] == 3'h7) |=> transmit_enable[1] && !setup_enable[1])
        else $error("setup allowed while control disabled");
    a_setup_allow: assert property (@(posedge aclk) disable iff (!aresetn)
        ep_we[1] && (s.w_data[4:2] == 3'h3) |=> setup_enable[1])
        else $error("setup not allowed");
    a_receive_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        ep_we[2] |=> receive_enable[2] == $past(s.w_data[3]))
        else $error("receive enable does not follow write");
    a_transmit_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        ep_we[3] |=> transmit_enable[3] == $past(s.w_data[2]))
        else $error("transmit enable does not follow write");
    a_handshake_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        ep_we[4] |=> handshake_enable[4] == $past(s.w_data[0]))
        else $error("handshake enable does not follow write");
    a_stall_irq: assert property (@(posedge aclk) disable iff (!aresetn)
        stall_event[5] && stall_mask[5] |=> ep_ctrl[5].stall_status && irq)
        else $error("stall not reported");
    a_reset_clear: assert property (@(posedge aclk)
        !aresetn |=> (receive_enable == 16'h0000) && (transmit_enable == 16'h0000) && !irq
        && (handshake_enable == 16'h0000) && !low_speed_direct_connect && !nak_retry_disable)
        else $error("outputs not cleared by reset");

    c_write_done: cover property (@(posedge aclk) disable iff (!aresetn) bvalid && bready);
    c_read_done: cover property (@(posedge aclk) disable iff (!aresetn) rvalid && rready);
    c_stall_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
    c_setup_on: cover property (@(posedge aclk) disable iff (!aresetn) setup_enable[0]);

endmodule : usb_endpoint_control

// *** usb_bus_model.sv ***
`timescale 1ns/10ps
module usb_bus_model (
    // Clock.
    input wire logic aclk,
    // Mode and stall events towards the block.
    output logic host_mode,
    output logic [15:0] stall_event
);
    initial begin
        host_mode = 1'b0;
        stall_event = 16'h0000;
    end

    task automatic set_host(input logic m);
        @(posedge aclk);
        host_mode <= m;
    endtask : set_host

    task automatic stall(input int n);
        @(posedge aclk);
        stall_event <= 16'h0001 << n;
        @(posedge aclk);
        stall_event <= 16'h0000;
    endtask : stall
endmodule : usb_bus_model

// *** usb_endpoint_control_test.sv ***
`timescale 1ns/10ps
module usb_endpoint_control_test;
    logic aclk;
    logic aresetn;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq, host_mode;
    logic low_speed_direct_connect, nak_retry_disable;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [15:0] stall_event, receive_enable, transmit_enable, setup_enable, handshake_enable;
    int miscompares = 0;
    int samples_checked = 0;

    usb_endpoint_control i_dut (
        .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .host_mode(host_mode), .stall_event(stall_event), .receive_enable(receive_enable),
        .transmit_enable(transmit_enable), .setup_enable(setup_enable),
        .handshake_enable(handshake_enable), .low_speed_direct_connect(low_speed_direct_connect),
        .nak_retry_disable(nak_retry_disable), .irq(irq)
    );

    usb_bus_model i_bus (
        .aclk(aclk),
        .host_mode(host_mode),
        .stall_event(stall_event)
    );

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        @(posedge aclk);
        while (bvalid !== 1'b1) @(posedge aclk);
        bready <= 1'b0;
        check($sformatf("bresp %h", a), {30'h0, bresp}, {30'h0, er});
    endtask : wchk

    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        @(posedge aclk);
        while (arready !== 1'b1) @(posedge aclk);
        arvalid <= 1'b0;
        rready <= 1'b1;
        @(posedge aclk);
        while (rvalid !== 1'b1) @(posedge aclk);
        rready <= 1'b0;
        check($sformatf("rdata %h", a), rdata, e);
        check($sformatf("rresp %h", a), {30'h0, rresp}, {30'h0, er});
    endtask : rchk

    task automatic t_reset;
        for (int i = 0; i < 16; i++) begin
            rchk(8'(4 * i), 32'h0, 2'h0);
        end
        rchk(8'h40, 32'h0, 2'h0);
        rchk(8'h44, 32'h0, 2'h0);
        check("grants", {receive_enable, setup_enable}, 32'h0);
    endtask : t_reset

    task automatic t_ep_zero;
        i_bus.set_host(1'b1);
        wchk(8'h00, 32'hFFFFFFFF, 2'h0);
        rchk(8'h48, 32'h00000001, 2'h0);
        rchk(8'h00, 32'h000000DF, 2'h0);
        check("low_speed", {31'h0, low_speed_direct_connect}, 32'h1);
        check("nak_retry", {31'h0, nak_retry_disable}, 32'h1);
        check("setup0", {31'h0, setup_enable[0]}, 32'h0);
        wchk(8'h00, 32'h0000000D, 2'h0);
        check("low_speed", {31'h0, low_speed_direct_connect}, 32'h0);
        check("nak_retry", {31'h0, nak_retry_disable}, 32'h0);
        wchk(8'h00, 32'h000000C0, 2'h0);
        i_bus.set_host(1'b0);
        rchk(8'h00, 32'h0, 2'h0);
        check("low_speed", {31'h0, low_speed_direct_connect}, 32'h0);
        wchk(8'h14, 32'h000000FF, 2'h0);
        rchk(8'h14, 32'h0000001F, 2'h0);
        // A write without the low byte lane must leave the endpoint untouched.
        wstrb <= 4'hE;
        wchk(8'h14, 32'h00000000, 2'h0);
        wstrb <= 4'hF;
        rchk(8'h14, 32'h0000001F, 2'h0);
        wchk(8'h14, 32'h00000000, 2'h0);
    endtask : t_ep_zero

    task automatic t_grants;
        logic [7:0] v [8] = '{8'h0C, 8'h1C, 8'h14, 8'h18, 8'h04, 8'h08, 8'h01, 8'h00};
        int ep;
        for (int i = 0; i < 8; i++) begin
            wchk(8'h3C, {24'h0, v[i]}, 2'h0);
            check("setup15", {31'h0, setup_enable[15]}, {31'h0, v[i][3] & v[i][2] & !v[i][4]});
            check("rx15", {31'h0, receive_enable[15]}, {31'h0, v[i][3]});
            check("tx15", {31'h0, transmit_enable[15]}, {31'h0, v[i][2]});
            check("hshk15", {31'h0, handshake_enable[15]}, {31'h0, v[i][0]});
            rchk(8'h3C, {24'h0, v[i]}, 2'h0);
        end
        // Spread the same codes over endpoints 0-7 in two rotations, clearing each afterwards.
        for (int j = 0; j < 2; j++) begin
            for (int i = 0; i < 8; i++) begin
                ep = (i + j) % 8;
                wchk(8'(4 * ep), {24'h0, v[i]}, 2'h0);
                check("setup_n", {31'h0, setup_enable[ep]}, {31'h0, v[i][3] & v[i][2] & !v[i][4]});
                check("rx_n", {31'h0, receive_enable[ep]}, {31'h0, v[i][3]});
                check("tx_n", {31'h0, transmit_enable[ep]}, {31'h0, v[i][2]});
                check("hshk_n", {31'h0, handshake_enable[ep]}, {31'h0, v[i][0]});
                wchk(8'(4 * ep), 32'h0, 2'h0);
            end
        end
    endtask : t_grants

    task automatic t_stall;
        wchk(8'h44, 32'h00000008, 2'h0);
        i_bus.stall(3);
        #1;
        check("irq", {31'h0, irq}, 32'h1);
        rchk(8'h0C, 32'h00000002, 2'h0);
        rchk(8'h40, 32'h00000008, 2'h0);
        wchk(8'h40, 32'h00000008, 2'h0);
        #1;
        check("irq", {31'h0, irq}, 32'h0);
        i_bus.stall(4);
        #1;
        check("irq", {31'h0, irq}, 32'h0);
        rchk(8'h40, 32'h00000010, 2'h0);
        wchk(8'h0C, 32'h0, 2'h0);
        rchk(8'h0C, 32'h0, 2'h0);
    endtask : t_stall

    task automatic t_unmapped;
        wchk(8'h80, 32'h000000FF, 2'h2);
        rchk(8'h80, 32'h0, 2'h2);
    endtask : t_unmapped

    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hF;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_ep_zero();
        t_grants();
        t_stall();
        t_unmapped();
        complete_run();
    end

    // The whole sequence needs well under a thousand bus cycles.
    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        complete_run();
    end
endmodule : usb_endpoint_control_test
